/* File: verilog/drive_enable_pkg.sv */
package drive_enable_pkg;

	// Register offsets (word index on the plain register port)
	localparam logic [3:0] ADDR_ENABLE_COND  = 4'h0;
	localparam logic [3:0] ADDR_SEQ_INPUTS   = 4'h1;
	localparam logic [3:0] ADDR_SW_ENABLE    = 4'h2;
	localparam logic [3:0] ADDR_IRQ_STATUS   = 4'h3;
	localparam logic [3:0] ADDR_IRQ_ENABLE   = 4'h4;
	localparam logic [3:0] ADDR_IRQ_CLEAR    = 4'h5;

	// Reset values
	localparam logic       SW_ENABLE_RESET   = 1'h1;
	localparam logic [3:0] IRQ_ENABLE_RESET  = 4'h0;

	// Enable condition field positions
	localparam int EC_HW_ENABLE   = 0;
	localparam int EC_SW_ENABLE   = 1;
	localparam int EC_REGEN       = 2;
	localparam int EC_UNUSED      = 3;
	localparam int EC_FIXED_ONE   = 4;
	localparam int EC_THERMAL_OK  = 5;
	localparam int EC_OPTIONS_OK  = 6;
	localparam int EC_SLOT_BASE   = 7;
	localparam int EC_NOT_STANDBY = 11;
	localparam int EC_WIDTH       = 12;
	localparam int SLOT_COUNT     = 4;

	// Sequencer input field positions
	localparam int SQ_FINAL_EN    = 0;
	localparam int SQ_UNUSED      = 1;
	localparam int SQ_UNDERVOLT   = 2;
	localparam int SQ_CONTACTOR   = 3;
	localparam int SQ_TRIPPED     = 4;
	localparam int SQ_SYNCED      = 5;
	localparam int SQ_WIDTH       = 6;

	// Interrupt event bit positions
	localparam int EV_FINAL_RISE  = 0;
	localparam int EV_FINAL_FALL  = 1;
	localparam int EV_TRIP        = 2;
	localparam int EV_UNDERVOLT   = 3;
	localparam int EV_WIDTH       = 4;

	// Raw condition inputs as gathered from the drive
	typedef struct packed {
		logic                  hw_enable;
		logic                  regen_mode;
		logic                  thermal_all_read;
		logic                  options_ready;
		logic                  options_timeout;
		logic [SLOT_COUNT-1:0] slot_disable;
		logic                  standby;
		logic                  under_voltage;
		logic                  contactor_closed;
		logic                  tripped;
		logic                  synchronized;
	} drive_cond_t;

	// Register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage

/* File: verilog/drive_enable_condition_status.sv */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
module drive_enable_condition_status (
	input  wire logic                          core_clk_in,
	input  wire logic                          reset_in,
	input  wire drive_enable_pkg::drive_cond_t cond_in,
	input  wire drive_enable_pkg::reg_req_t    reg_req_in,
	output logic [31:0]                        reg_rdata_out,
	output logic                               final_enable_out,
	output logic                               irq_out
);

	// Register map, word index on the plain port
	//   Index 0: enable condition word, read only, 12 bits
	//   Index 1: sequencer input word, read only, 6 bits
	//   Index 2: software drive enable, bit 0, read and write
	//   Index 3: interrupt status, read only, sticky bits
	//   Index 4: interrupt enable, read and write
	//   Index 5: interrupt clear, write ones to clear
	//   Any other index reads zero and ignores writes
	//
	// Enable condition word layout
	//   Bit 0: hardware enable, after the synchroniser
	//   Bit 1: software drive enable register
	//   Bit 2: regenerative mode indication
	//   Bit 3: no condition, always zero
	//   Bit 4: constant one
	//   Bit 5: thermal model has read every thermistor
	//   Bit 6: option modules ready, or their wait ran out
	//   Bits 7 to 10: per slot, zero while that slot blocks
	//   Bit 11: zero while in standby
	//
	// Sequencer input word layout
	//   Bit 0: final drive enable
	//   Bit 1: unused, always zero
	//   Bit 2: DC link under-voltage
	//   Bit 3: charge contactor closed
	//   Bit 4: drive tripped
	//   Bit 5: front end synchronised to supply
	//
	// Interrupt event layout
	//   Bit 0: final enable rose
	//   Bit 1: final enable fell
	//   Bit 2: trip began
	//   Bit 3: under-voltage began
	//
	// Timing through the block
	//   Condition sampled at edge k enters the first flop
	//   Second flop holds it one edge later
	//   Status words and final enable follow one edge after that
	//   Read data stands only in the cycle after the read strobe
	//   Interrupt output follows status with no extra delay
	//
	// Latency trade-off
	//   Three edges from pin to final enable
	//   Cheap compared with drive sequencer reaction times
	//   Buys a glitch free, metastability safe enable
	//
	// Readiness latches
	//   Thermal and option readiness only ever rise
	//   A later drop of those inputs is ignored until reset
	//   Thermal and option latches lag the other bits by one edge
	//
	// Software enable
	//   Resets to one so a drive with no host can run
	//   Clearing it removes bit 1 and blocks final enable
	//   Only bit 0 of the write data is kept
	//
	// Interrupt behaviour
	//   Status bits stay set until software clears them
	//   An event in the same cycle as its clear wins
	//   Enable bits mask the output, not the status
	//   Output is a level, high while any enabled bit is set
	//
	// Register port limits
	//   Writes and reads are single cycle, never both at once
	//   The port never stalls the master
	//   Writes to read-only words are silently dropped
	//
	// Hazards for users
	//   Conditions shorter than one clock may be missed
	//   Edge events need the level to hold only one edge
	//   Read data is zero outside its one valid cycle

	// Conditions come from other domains and pins: two-stage synchroniser
	drive_enable_pkg::drive_cond_t cond_meta_reg;
	drive_enable_pkg::drive_cond_t cond_sync_reg;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			cond_meta_reg <= '0;
			cond_sync_reg <= '0;
		end else begin
			cond_meta_reg <= cond_in;
			cond_sync_reg <= cond_meta_reg;
		end
	end

	// Software drive enable, on by default so a bare drive can run
	logic sw_enable_reg;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			sw_enable_reg <= drive_enable_pkg::SW_ENABLE_RESET;
		end else if (reg_req_in.wr && reg_req_in.addr == drive_enable_pkg::ADDR_SW_ENABLE) begin
			sw_enable_reg <= reg_req_in.wdata[0];
		end
	end

	// Thermal and option readiness latch once; they never fall back
	logic thermal_ok_reg;
	logic options_ok_reg;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			thermal_ok_reg <= 1'h0;
			options_ok_reg <= 1'h0;
		end else begin
			if (cond_sync_reg.thermal_all_read) begin
				thermal_ok_reg <= 1'h1;
			end
			if (cond_sync_reg.options_ready || cond_sync_reg.options_timeout) begin
				options_ok_reg <= 1'h1;
			end
		end
	end

	// One ready bit per option slot; low while that slot holds the drive off
	logic [drive_enable_pkg::SLOT_COUNT-1:0] slot_ok;

	genvar slot_idx;

	// Slot 1 lands in the lowest slot bit of the word
	generate
		for (slot_idx = 0; slot_idx < drive_enable_pkg::SLOT_COUNT; slot_idx++) begin : g_slot
			assign slot_ok[slot_idx] = ~cond_sync_reg.slot_disable[slot_idx];
		end
	endgenerate

	// Enable condition word assembled combinationally
	logic [drive_enable_pkg::EC_WIDTH-1:0] enable_cond_next;
	logic [drive_enable_pkg::EC_WIDTH-1:0] enable_cond_mask;

	always_comb begin
		enable_cond_next = '0;
		enable_cond_next[drive_enable_pkg::EC_HW_ENABLE]   = cond_sync_reg.hw_enable;
		enable_cond_next[drive_enable_pkg::EC_SW_ENABLE]   = sw_enable_reg;
		enable_cond_next[drive_enable_pkg::EC_REGEN]       = cond_sync_reg.regen_mode;
		enable_cond_next[drive_enable_pkg::EC_UNUSED]      = 1'h0;
		enable_cond_next[drive_enable_pkg::EC_FIXED_ONE]   = 1'h1;
		enable_cond_next[drive_enable_pkg::EC_THERMAL_OK]  = thermal_ok_reg;
		enable_cond_next[drive_enable_pkg::EC_OPTIONS_OK]  = options_ok_reg;
		enable_cond_next[drive_enable_pkg::EC_NOT_STANDBY] = ~cond_sync_reg.standby;
		enable_cond_next[drive_enable_pkg::EC_SLOT_BASE +: drive_enable_pkg::SLOT_COUNT] =
			slot_ok;
	end

	// Bit 3 is not a condition, so it is masked out of the final enable
	always_comb begin
		enable_cond_mask = '1;
		enable_cond_mask[drive_enable_pkg::EC_UNUSED] = 1'h0;
	end

	// Final enable: all conditions must hold; clearing sw enable blocks it
	logic final_enable_next;

	assign final_enable_next = &(enable_cond_next | ~enable_cond_mask);

	// Status words registered so reads and output see one consistent snapshot
	logic [drive_enable_pkg::EC_WIDTH-1:0] enable_cond_reg;
	logic [drive_enable_pkg::SQ_WIDTH-1:0] seq_inputs_reg;
	logic                                  final_enable_reg;

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			enable_cond_reg  <= '0;
			final_enable_reg <= 1'h0;
		end else begin
			enable_cond_reg  <= enable_cond_next;
			final_enable_reg <= final_enable_next;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			seq_inputs_reg <= '0;
		end else begin
			seq_inputs_reg[drive_enable_pkg::SQ_FINAL_EN]  <= final_enable_next;
			seq_inputs_reg[drive_enable_pkg::SQ_UNUSED]    <= 1'h0;
			seq_inputs_reg[drive_enable_pkg::SQ_UNDERVOLT] <= cond_sync_reg.under_voltage;
			seq_inputs_reg[drive_enable_pkg::SQ_CONTACTOR] <= cond_sync_reg.contactor_closed;
			seq_inputs_reg[drive_enable_pkg::SQ_TRIPPED]   <= cond_sync_reg.tripped;
			seq_inputs_reg[drive_enable_pkg::SQ_SYNCED]    <= cond_sync_reg.synchronized;
		end
	end

	assign final_enable_out = final_enable_reg;

	// Interrupt events: edges of final enable, trip and under-voltage onset
	logic [drive_enable_pkg::EV_WIDTH-1:0] event_now;
	logic [drive_enable_pkg::EV_WIDTH-1:0] irq_status_reg;
	logic [drive_enable_pkg::EV_WIDTH-1:0] irq_enable_reg;
	logic [drive_enable_pkg::EV_WIDTH-1:0] irq_clear;

	always_comb begin
		event_now = '0;
		event_now[drive_enable_pkg::EV_FINAL_RISE] = final_enable_next & ~final_enable_reg;
		event_now[drive_enable_pkg::EV_FINAL_FALL] = ~final_enable_next & final_enable_reg;
		event_now[drive_enable_pkg::EV_TRIP]       = cond_sync_reg.tripped &
			~seq_inputs_reg[drive_enable_pkg::SQ_TRIPPED];
		event_now[drive_enable_pkg::EV_UNDERVOLT]  = cond_sync_reg.under_voltage &
			~seq_inputs_reg[drive_enable_pkg::SQ_UNDERVOLT];
	end

	assign irq_clear = (reg_req_in.wr && reg_req_in.addr == drive_enable_pkg::ADDR_IRQ_CLEAR) ?
		reg_req_in.wdata[drive_enable_pkg::EV_WIDTH-1:0] : '0;

	// Set wins over a clear in the same cycle so no event is lost
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			irq_status_reg <= '0;
		end else begin
			irq_status_reg <= (irq_status_reg & ~irq_clear) | event_now;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			irq_enable_reg <= drive_enable_pkg::IRQ_ENABLE_RESET;
		end else if (reg_req_in.wr && reg_req_in.addr == drive_enable_pkg::ADDR_IRQ_ENABLE) begin
			irq_enable_reg <= reg_req_in.wdata[drive_enable_pkg::EV_WIDTH-1:0];
		end
	end

	assign irq_out = |(irq_status_reg & irq_enable_reg);

	// Read data one cycle after the strobe, zero otherwise and when unmapped
	// Zero outside the valid cycle keeps a shared read bus simple to OR
	// Status words are read from their snapshot flops, not the raw terms
	// Clear register reads zero, being write only
	always_ff @(posedge core_clk_in) begin
		if (reset_in) begin
			reg_rdata_out <= 32'h0;
		end else if (reg_req_in.rd) begin
			case (reg_req_in.addr)
				drive_enable_pkg::ADDR_ENABLE_COND: reg_rdata_out <= {20'h0, enable_cond_reg};
				drive_enable_pkg::ADDR_SEQ_INPUTS:  reg_rdata_out <= {26'h0, seq_inputs_reg};
				drive_enable_pkg::ADDR_SW_ENABLE:   reg_rdata_out <= {31'h0, sw_enable_reg};
				drive_enable_pkg::ADDR_IRQ_STATUS:  reg_rdata_out <= {28'h0, irq_status_reg};
				drive_enable_pkg::ADDR_IRQ_ENABLE:  reg_rdata_out <= {28'h0, irq_enable_reg};
				default:                            reg_rdata_out <= 32'h0;
			endcase
		end else begin
			reg_rdata_out <= 32'h0;
		end
	end

endmodule

/* File: dv/drive_enable_condition_status_assertions.sv */
`timescale 1ns/1ps
// Port checks; read data is judged in the cycle after its strobe
module drive_enable_condition_status_assertions (
	input  wire logic                          core_clk_in,
	input  wire logic                          reset_in,
	input  wire drive_enable_pkg::drive_cond_t cond_in,
	input  wire drive_enable_pkg::reg_req_t    reg_req_in,
	input  wire logic [31:0]                   reg_rdata_out,
	input  wire logic                          final_enable_out,
	input  wire logic                          irq_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	// Read port shape
	a_rdata_idle: assert property (!$past(reg_req_in.rd) |-> reg_rdata_out == 32'h0)
		else $error("read data not idle");
	a_upper_zero: assert property ($past(reg_req_in.rd) |-> reg_rdata_out[31:12] == 20'h0)
		else $error("read data upper bits set");
	a_fixed_bits: assert property ($past(reg_req_in.rd) && $past(reg_req_in.addr) == 4'h0 |->
		reg_rdata_out[4:3] == 2'b10) else $error("fixed enable bits wrong");
	// Sequencer word, four flops from input to read data
	a_seq_unused: assert property ($past(reg_req_in.rd) && $past(reg_req_in.addr) == 4'h1 |->
		!reg_rdata_out[1]) else $error("unused sequencer bit set");
	a_seq_final: assert property ($past(reg_req_in.rd) && $past(reg_req_in.addr) == 4'h1 |->
		reg_rdata_out[0] == $past(final_enable_out)) else $error("sequencer final bit wrong");
	a_undervolt_bit: assert property ($past(reg_req_in.rd) && $past(reg_req_in.addr) == 4'h1 |->
		reg_rdata_out[2] == $past(cond_in.under_voltage, 4)) else $error("under-voltage bit wrong");
	// Final enable needs each gate three edges earlier
	a_hw_gate: assert property (final_enable_out |-> $past(cond_in.hw_enable, 3))
		else $error("final enable without hardware enable");
	a_standby_gate: assert property (final_enable_out |-> !$past(cond_in.standby, 3))
		else $error("final enable in standby");
	a_slot_gate: assert property (final_enable_out |-> $past(cond_in.slot_disable, 3) == 4'h0)
		else $error("final enable with slot disable");
endmodule
bind drive_enable_condition_status drive_enable_condition_status_assertions u_chk (.core_clk_in(core_clk_in),
	.reset_in(reset_in), .cond_in(cond_in), .reg_req_in(reg_req_in), .reg_rdata_out(reg_rdata_out),
	.final_enable_out(final_enable_out), .irq_out(irq_out));

/* File: dv/drive_enable_condition_status_tb_top.sv */
`timescale 1ns/1ps
module drive_enable_condition_status_tb_top;
	logic                          core_clk_in;
	logic                          reset_in;
	drive_enable_pkg::drive_cond_t cond;
	drive_enable_pkg::drive_cond_t c;
	drive_enable_pkg::reg_req_t    req;
	logic [31:0]                   rdata;
	logic [31:0]                   d;
	logic                          final_en;
	logic                          irq;
	logic                          th;
	logic                          op;
	logic                          sw;
	int                            num_errors = 0;
	int                            total_checks = 0;
	int                            cycles = 0;
	drive_enable_condition_status uut (.core_clk_in(core_clk_in), .reset_in(reset_in), .cond_in(cond),
		.reg_req_in(req), .reg_rdata_out(rdata), .final_enable_out(final_en), .irq_out(irq));
	// Clock
	initial begin
		core_clk_in = 1'b0;
		forever #5 core_clk_in = ~core_clk_in;
	end
	// Hang guard, well above the roughly 600 cycles needed
	always @(posedge core_clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// One-cycle strobes launched after an edge
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge core_clk_in);
		req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk_in);
		req.wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge core_clk_in);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk_in);
		req.rd <= 1'b0;
		#1;
		v = rdata;
	endtask
	// Expected enable word; thermal and option readiness are sticky
	function automatic logic [11:0] exp_en(input drive_enable_pkg::drive_cond_t x);
		return {~x.standby, ~x.slot_disable, op, th, 1'b1, 1'b0, x.regen_mode, sw, x.hw_enable};
	endfunction
	// Hold conditions past the sync delay, then check both words
	task automatic apply(input drive_enable_pkg::drive_cond_t x);
		logic [11:0] e;
		@(posedge core_clk_in);
		cond <= x;
		th = th | x.thermal_all_read;
		op = op | x.options_ready | x.options_timeout;
		repeat (4) @(posedge core_clk_in);
		#1;
		e = exp_en(x);
		chk("final", {31'h0, &{e[11:4], e[2:0]}}, {31'h0, final_en});
		rd(4'h0, d);
		chk("enable word", {20'h0, e}, d);
		rd(4'h1, d);
		chk("seq word", {26'h0, x.synchronized, x.tripped, x.contactor_closed, x.under_voltage, 1'b0,
			&{e[11:4], e[2:0]}}, d);
	endtask
	// Main sequence: corners first, then random conditions
	initial begin
		void'($urandom(32'h1CA3));
		reset_in = 1'b1;
		cond = '0;
		req = '0;
		th = 1'b0;
		op = 1'b0;
		sw = 1'b1;
		repeat (20) @(posedge core_clk_in);
		reset_in <= 1'b0;
		rd(4'h2, d);
		chk("sw enable reset", 32'h1, d);
		rd(4'hF, d);
		chk("unmapped read", 32'h0, d);
		wr(4'h4, 32'h1);
		apply(14'h3000);
		apply(14'h3A00);
		chk("irq raised", 32'h1, {31'h0, irq});
		rd(4'h3, d);
		chk("irq status", 32'h1, d);
		wr(4'h4, 32'h0);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(4'h5, 32'h1);
		rd(4'h3, d);
		chk("irq cleared", 32'h0, d);
		wr(4'h2, 32'h0);
		sw = 1'b0;
		wr(4'h0, 32'hFFF);
		apply(14'h3A00);
		wr(4'h2, 32'h1);
		sw = 1'b1;
		// Half the draws forced towards a full enable
		repeat (60) begin
			c = drive_enable_pkg::drive_cond_t'(14'($urandom));
			if ($urandom % 2) c = (c & 14'h3E0F) | 14'h3000;
			apply(c);
		end
		test_done();
	end
endmodule
